// File: src/omcs_pkg.sv
// Constants for the optical module control and status block.
// Assumes a single 200 MHz system clock and a two-wire slave clocked from it.
package omcs_pkg;
  localparam logic [6:0] OMCS_ADDR_ID = 7'h50;    // 0xa0 >> 1
  localparam logic [6:0] OMCS_ADDR_DIAG = 7'h51;  // 0xa2 >> 1
  localparam logic [6:0] OMCS_ADDR_TEST = 7'h58;  // 0xb0 >> 1, reserved, not answered
  localparam logic [7:0] OMCS_STATUS_OFS = 8'h6e;
  localparam int OMCS_BIT_TXOFF_STATE = 7;
  localparam int OMCS_BIT_TXOFF_SOFT = 6;
  localparam int OMCS_BIT_FAULT = 2;
  localparam int OMCS_BIT_RXLOST = 1;
  localparam logic [7:0] OMCS_OFS_TEMP = 8'h60;
  localparam logic [7:0] OMCS_OFS_VCC = 8'h62;
  localparam logic [7:0] OMCS_OFS_BIAS = 8'h64;
  localparam logic [7:0] OMCS_OFS_TXPWR = 8'h66;
  localparam logic [7:0] OMCS_OFS_RXPWR = 8'h68;
  localparam logic [7:0] OMCS_STATUS_RESET = 8'h00;
  typedef enum logic [2:0] {
    OMCS_IDLE, OMCS_ADDR, OMCS_ACK, OMCS_WDATA, OMCS_RDATA, OMCS_RACK
  } omcs_state_t;
endpackage

// File: src/optical_module_control_status.sv
// Control and status logic of a pluggable optical module: fault latch,
// transmit-off, eye-safety cut and a two-wire management slave.
// Assumes the host drives the pins; the monitors are sampled analog words.
`timescale 1ns/100ps
// Functional notes
// - The serial slave answers at 0xa0 and 0xa2, each a 256-byte space.
// - Page 0xb0 is reserved for internal test and is not answered to the host.
// - The laser is off while the transmit-off pin is high and on while it is low.
// - An undriven transmit-off pin counts as high, keeping the laser off.
// - Asserting then releasing the transmit-off pin clears the latched fault.
// - Soft transmit-off bit 6 of diagnostic byte 110 is ORed with the pin.
// - Bit 7 of byte 110 reads the current transmit-off state.
// - A laser fault raises the fault output and turns the laser off.
// - The fault latches and clears only on a transmit-off toggle or reset.
// - Bit 2 of byte 110 reads the fault state.
// - An unsafe output power condition turns the transmitter off.
// - Receive-signal-lost is high for unusable input and low otherwise.
// - Bit 1 of byte 110 reads the receive-signal-lost state.
// - Diagnostic bytes give temperature, supply, bias, tx and rx power.
module optical_module_control_status
  import omcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic txOffPin,
  input wire logic txOffDriven,
  input wire logic laserFault,
  input wire logic powerUnsafe,
  input wire logic rxInputBad,
  input wire logic [15:0] monTemp,
  input wire logic [15:0] monVcc,
  input wire logic [15:0] monBias,
  input wire logic [15:0] monTxPower,
  input wire logic [15:0] monRxPower,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic laserEnable,
  output logic txFault,
  output logic receive_signal_lost
);
  logic [1:0] offSync_q, sclSync_q, sdaSync_q, rawSync_q;
  logic [1:0] unsafeSync_q, faultSync_q, drvSync_q;
  logic offLevel;
  logic txOff, fault_q, offPrev_q, sawOff_q, softOff_q, rxLost_q;
  logic sclPrev_q, sdaPrev_q;
  logic [7:0] idMem [0:255];
  logic [7:0] diagMem [0:255];

  // Pin and driven flag get their own flops; an OR ahead of them could glitch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      offSync_q <= 2'h3;
      drvSync_q <= 2'h0;
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      unsafeSync_q <= 2'h0;
      faultSync_q <= 2'h0;
      rawSync_q <= 2'h0;
    end else if (clkEn) begin
      offSync_q <= {offSync_q[0], txOffPin};
      drvSync_q <= {drvSync_q[0], txOffDriven};
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      unsafeSync_q <= {unsafeSync_q[0], powerUnsafe};
      faultSync_q <= {faultSync_q[0], laserFault};
      rawSync_q <= {rawSync_q[0], rxInputBad};
    end
  end

  assign offLevel = offSync_q[1] | ~drvSync_q[1];
  assign txOff = offLevel | softOff_q;

  // Fault latch; a new fault in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
      offPrev_q <= 1'b1;
      sawOff_q <= 1'b0;
    end else if (clkEn) begin
      offPrev_q <= offLevel;
      if (faultSync_q[1] || unsafeSync_q[1]) begin
        fault_q <= 1'b1;
        sawOff_q <= 1'b0;
      end else if (fault_q && offLevel) begin
        sawOff_q <= 1'b1;
      end else if (fault_q && sawOff_q && offPrev_q && !offLevel) begin
        fault_q <= 1'b0;
        sawOff_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      laserEnable <= 1'b0;
      txFault <= 1'b0;
      receive_signal_lost <= 1'b1;
      rxLost_q <= 1'b1;
    end else if (clkEn) begin
      laserEnable <= ~txOff & ~fault_q & ~unsafeSync_q[1];
      txFault <= fault_q;
      rxLost_q <= rawSync_q[1];
      receive_signal_lost <= rawSync_q[1];
    end
  end

  // Two-wire slave
  omcs_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q, ptr_q;
  logic diagSel_q, rw_q, gotPtr_q, ackOk_q;
  logic sclRise, sclFall, start, stop;
  logic [7:0] rdByte, statusByte;

  assign sclRise = sclSync_q[1] & ~sclPrev_q;
  assign sclFall = ~sclSync_q[1] & sclPrev_q;
  assign start = sclSync_q[1] & sdaPrev_q & ~sdaSync_q[1];
  assign stop = sclSync_q[1] & ~sdaPrev_q & sdaSync_q[1];

  always_comb begin
    statusByte = 8'h00;
    statusByte[OMCS_BIT_TXOFF_STATE] = txOff;
    statusByte[OMCS_BIT_TXOFF_SOFT] = softOff_q;
    statusByte[OMCS_BIT_FAULT] = fault_q;
    statusByte[OMCS_BIT_RXLOST] = rxLost_q;
  end

  always_comb begin
    if (!diagSel_q) begin
      rdByte = idMem[ptr_q];
    end else begin
      case (ptr_q)
        OMCS_STATUS_OFS: rdByte = statusByte;
        OMCS_OFS_TEMP: rdByte = monTemp[15:8];
        OMCS_OFS_TEMP + 8'h01: rdByte = monTemp[7:0];
        OMCS_OFS_VCC: rdByte = monVcc[15:8];
        OMCS_OFS_VCC + 8'h01: rdByte = monVcc[7:0];
        OMCS_OFS_BIAS: rdByte = monBias[15:8];
        OMCS_OFS_BIAS + 8'h01: rdByte = monBias[7:0];
        OMCS_OFS_TXPWR: rdByte = monTxPower[15:8];
        OMCS_OFS_TXPWR + 8'h01: rdByte = monTxPower[7:0];
        OMCS_OFS_RXPWR: rdByte = monRxPower[15:8];
        OMCS_OFS_RXPWR + 8'h01: rdByte = monRxPower[7:0];
        default: rdByte = diagMem[ptr_q];
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= OMCS_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      diagSel_q <= 1'b0;
      rw_q <= 1'b0;
      gotPtr_q <= 1'b0;
      ackOk_q <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      softOff_q <= OMCS_STATUS_RESET[OMCS_BIT_TXOFF_SOFT];
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
      if (start) begin
        state_q <= OMCS_ADDR;
        bitCnt_q <= 4'h0;
        gotPtr_q <= 1'b0;
        sdaOe <= 1'b0;
      end else if (stop) begin
        state_q <= OMCS_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_q)
          OMCS_IDLE: sdaOe <= 1'b0;
          OMCS_ADDR, OMCS_WDATA: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaSync_q[1]};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == OMCS_ADDR) begin
                ackOk_q <= shift_q[7:1] == OMCS_ADDR_ID || shift_q[7:1] == OMCS_ADDR_DIAG;
                diagSel_q <= shift_q[7:1] == OMCS_ADDR_DIAG;
                rw_q <= shift_q[0];
                sdaOe <= shift_q[7:1] == OMCS_ADDR_ID || shift_q[7:1] == OMCS_ADDR_DIAG;
              end else begin
                ackOk_q <= 1'b1;
                sdaOe <= 1'b1;
                if (!gotPtr_q) begin
                  ptr_q <= shift_q;
                  gotPtr_q <= 1'b1;
                end else begin
                  if (diagSel_q && ptr_q == OMCS_STATUS_OFS) begin
                    softOff_q <= shift_q[OMCS_BIT_TXOFF_SOFT];
                  end else if (diagSel_q) begin
                    diagMem[ptr_q] <= shift_q;
                  end else begin
                    idMem[ptr_q] <= shift_q;
                  end
                  ptr_q <= ptr_q + 8'h01;
                end
              end
              sdaOut <= 1'b0;
              state_q <= OMCS_ACK;
            end
          end
          OMCS_ACK: begin
            if (sclFall) begin
              if (!ackOk_q) begin
                sdaOe <= 1'b0;
                state_q <= OMCS_IDLE;
              end else if (rw_q) begin
                shift_q <= {rdByte[6:0], 1'b0};
                sdaOut <= rdByte[7];
                sdaOe <= ~rdByte[7];
                bitCnt_q <= 4'h1;
                ptr_q <= ptr_q + 8'h01;
                state_q <= OMCS_RDATA;
              end else begin
                sdaOe <= 1'b0;
                state_q <= OMCS_WDATA;
              end
            end
          end
          OMCS_RDATA: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe <= 1'b0;
                state_q <= OMCS_RACK;
              end else begin
                sdaOut <= shift_q[7];
                sdaOe <= ~shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          OMCS_RACK: begin
            if (sclRise) begin
              ackOk_q <= ~sdaSync_q[1];
              state_q <= sdaSync_q[1] ? OMCS_IDLE : OMCS_ACK;
            end
          end
          default: state_q <= OMCS_IDLE;
        endcase
      end
    end
  end
endmodule

// File: tb/omcs_asserts.sv
`timescale 1ns/100ps
// Checker on the pin-level behaviour of the control block.
// Assumes clkEn high; pins reach outputs within four clocks.
module omcs_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic txOffPin,
  input wire logic txOffDriven,
  input wire logic laserFault,
  input wire logic powerUnsafe,
  input wire logic rxInputBad,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic laserEnable,
  input wire logic txFault,
  input wire logic receive_signal_lost
);
  logic [3:0] sinceOff_q;
  // Clears of the fault must follow a recent off request
  always_ff @(posedge sys_clk) begin
    if (txOffPin || !txOffDriven)
      sinceOff_q <= 4'h0;
    else if (sinceOff_q != 4'hf)
      sinceOff_q <= sinceOff_q + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_pin_off: assert property ((txOffPin && txOffDriven)[*5] |-> !laserEnable)
    else $error("laser on while pin high");
  a_undriven_off: assert property ((!txOffDriven)[*5] |-> !laserEnable)
    else $error("laser on while pin undriven");
  a_fault_sets: assert property ($rose(laserFault) |-> ##[1:4] (txFault && !laserEnable))
    else $error("fault not raised");
  a_fault_clear: assert property ($fell(txFault) |-> sinceOff_q < 4'h8)
    else $error("fault cleared without toggle");
  a_unsafe_off: assert property (powerUnsafe[*5] |-> !laserEnable)
    else $error("laser on while unsafe");
  a_lost_high: assert property (rxInputBad[*5] |-> receive_signal_lost)
    else $error("signal lost not high");
  a_lost_low: assert property ((!rxInputBad)[*5] |-> !receive_signal_lost)
    else $error("signal lost not low");
  a_ack_scl_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("slave drove while clock high");
  a_sda_pulls_low: assert property (sdaOe |-> !sdaOut)
    else $error("slave drove data high");
  cover property ($rose(txFault));
  cover property ($fell(txFault));
  cover property ($rose(sdaOe));
endmodule
bind optical_module_control_status omcs_asserts omcs_asserts_i (.*);

// File: tb/omcs_host.sv
`timescale 1ns/100ps
// Host model: two-wire management master on the module pins.
// Assumes a pull-up on the data wire, resolved here from both enables.
module omcs_host (
  input wire logic sys_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sdaLow = 1'b0;
  initial sclIn = 1'b1;
  assign sdaIn = !(sdaLow || sdaOe);
  // Ten clocks per phase keeps well above the slave's sampling need
  task automatic hp();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic start();
    sdaLow = 1'b0;
    hp();
    sclIn = 1'b1;
    hp();
    sdaLow = 1'b1;
    hp();
    sclIn = 1'b0;
    hp();
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    hp();
    sclIn = 1'b1;
    hp();
    sdaLow = 1'b0;
    hp();
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sdaLow = !tx[i];
      hp();
      sclIn = 1'b1;
      hp();
      rx[i] = sdaIn;
      sclIn = 1'b0;
      hp();
    end
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, dat, output logic ack);
    logic [8:0] q;
    start();
    xfer({dev, 2'b01}, q);
    ack = !q[0];
    xfer({ofs, 1'b1}, q);
    xfer({dat, 1'b1}, q);
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic ack,
                    output logic [7:0] dat);
    logic [8:0] q;
    start();
    xfer({dev, 2'b01}, q);
    ack = !q[0];
    xfer({ofs, 1'b1}, q);
    start();
    xfer({dev, 2'b11}, q);
    xfer(9'h1ff, q);
    dat = q[8:1];
    stop();
  endtask
  // The master acks the first byte, so the slave moves on to the next offset
  task automatic rdPair(input logic [6:0] dev, input logic [7:0] ofs,
                        output logic [15:0] dat);
    logic [8:0] q;
    start();
    xfer({dev, 2'h1}, q);
    xfer({ofs, 1'h1}, q);
    start();
    xfer({dev, 2'h3}, q);
    xfer(9'h1fe, q);
    dat[15:8] = q[8:1];
    xfer(9'h1ff, q);
    dat[7:0] = q[8:1];
    stop();
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
// Bench: pin stimulus plus management reads and writes through the host model.
// Assumes one off pulse per run, as the host must space them widely.
module testbench import omcs_pkg::*;;
  logic sys_clk = 1'b0, rstn = 1'b0, txOffPin = 1'b0, txOffDriven = 1'b0;
  logic laserFault = 1'b0, powerUnsafe = 1'b0, rxInputBad = 1'b0, ack;
  logic sclIn, sdaIn, sdaOut, sdaOe, laserEnable, txFault, receive_signal_lost;
  logic [15:0] mon [5] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3};
  logic [7:0] r;
  logic [15:0] w;
  logic clkEn = 1'h1;
  int errTotal = 0, nChecks = 0;
  optical_module_control_status optical_module_control_status_i (.clkEn(clkEn),
    .monTemp(mon[0]), .monVcc(mon[1]), .monBias(mon[2]), .monTxPower(mon[3]),
    .monRxPower(mon[4]), .*);
  omcs_host omcs_host_i (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic reportAndStop();
    if (errTotal == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // The tests take about 20k clocks; twice that means something hung
  initial begin
    #200us;
    errTotal++;
    reportAndStop();
  end
  initial begin
    cyc(3);
    rstn = 1'b1;
    cyc(8);
    chk1(laserEnable, 1'b0);
    txOffDriven = 1'b1;
    cyc(8);
    chk1(laserEnable, 1'b1);
    chk1(receive_signal_lost, 1'b0);
    clkEn = 1'h0;
    rxInputBad = 1'h1;
    cyc(3);
    chk1(receive_signal_lost, 1'h0);
    rxInputBad = 1'h0;
    clkEn = 1'h1;
    cyc(4);
    chk1(receive_signal_lost, 1'h0);
    for (int k = 0; k < 5; k++) begin
      omcs_host_i.rd(OMCS_ADDR_DIAG, OMCS_OFS_TEMP + 8'(2 * k), ack, r);
      chk8(r, mon[k][15:8]);
    end
    omcs_host_i.rd(OMCS_ADDR_DIAG, OMCS_OFS_TEMP + 8'h01, ack, r);
    chk8(r, mon[0][7:0]);
    omcs_host_i.rdPair(OMCS_ADDR_DIAG, OMCS_OFS_RXPWR, w);
    chk8(w[15:8], mon[4][15:8]);
    chk8(w[7:0], mon[4][7:0]);
    omcs_host_i.wr(OMCS_ADDR_ID, 8'hff, 8'h5a, ack);
    omcs_host_i.rd(OMCS_ADDR_ID, 8'hff, ack, r);
    chk1(ack, 1'b1);
    chk8(r, 8'h5a);
    omcs_host_i.rd(OMCS_ADDR_TEST, 8'h00, ack, r);
    chk1(ack, 1'b0);
    omcs_host_i.wr(OMCS_ADDR_DIAG, OMCS_STATUS_OFS, 8'h40, ack);
    cyc(8);
    chk1(laserEnable, 1'b0);
    omcs_host_i.rd(OMCS_ADDR_DIAG, OMCS_STATUS_OFS, ack, r);
    chk8(r, 8'hc0);
    omcs_host_i.wr(OMCS_ADDR_DIAG, OMCS_STATUS_OFS, 8'h00, ack);
    cyc(8);
    chk1(laserEnable, 1'b1);
    rxInputBad = 1'b1;
    cyc(8);
    chk1(receive_signal_lost, 1'b1);
    omcs_host_i.rd(OMCS_ADDR_DIAG, OMCS_STATUS_OFS, ack, r);
    chk8(r & 8'h02, 8'h02);
    rxInputBad = 1'b0;
    laserFault = 1'b1;
    cyc(4);
    laserFault = 1'b0;
    cyc(20);
    chk1(txFault, 1'b1);
    chk1(laserEnable, 1'b0);
    omcs_host_i.rd(OMCS_ADDR_DIAG, OMCS_STATUS_OFS, ack, r);
    chk8(r & 8'h04, 8'h04);
    txOffPin = 1'b1;
    cyc(8);
    txOffPin = 1'b0;
    cyc(8);
    chk1(txFault, 1'b0);
    chk1(laserEnable, 1'b1);
    powerUnsafe = 1'b1;
    cyc(8);
    chk1(laserEnable, 1'b0);
    powerUnsafe = 1'h0;
    rstn = 1'h0;
    cyc(3);
    chk1(txFault, 1'h0);
    chk1(receive_signal_lost, 1'h1);
    rstn = 1'h1;
    cyc(8);
    chk1(txFault, 1'h0);
    chk1(laserEnable, 1'h1);
    reportAndStop();
  end
endmodule
